// file: hw/stm_consts.vh
// Constants for the speed regulator output stage and torque mode selector.
// Assumes signed fixed-point torque values, Q-format fractions with FRAC bits.
`ifndef STM_CONSTS_VH
`define STM_CONSTS_VH
`define STM_DATA_W 16
`define STM_FRAC_W 12
`define STM_GAIN_ONE 16'h1000
`define STM_CTRL_REG_EN_BIT 8
`define STM_CTRL_W 16
`define STM_ADAPT_EN_BIT 0
`define STM_MODE_W 4
`define STM_MODE_ZERO 4'h0
`define STM_MODE_SPEED 4'h1
`define STM_MODE_TORQUE 4'h2
`define STM_MODE_MIN 4'h3
`define STM_MODE_MAX 4'h4
`define STM_MODE_SUM 4'h5
`define STM_MODE_ABSMIN 4'h6
`define STM_MODE_LAT_MIN 4'h7
`define STM_MODE_LAT_MAX 4'h8
`define STM_MODE_RESET 4'h1
`endif

// file: hw/stm_lead_lag.v
// First-order lead/lag filter, one update per strobe.
// Assumes gain and bandwidth coefficients already scaled to the update period.
`include "stm_consts.vh"
module stm_lead_lag #(
	parameter W = 16,
	parameter F = 12
) (
	// Clock and control
	input wire clk_i,
	input wire nrst_i,
	input wire ce_i,
	input wire upd_i,
	// Coefficients: gain (lead ratio) and bandwidth per step, Q F
	input wire signed [W-1:0] gain_i,
	input wire signed [W-1:0] bw_i,
	// Data
	input wire signed [W-1:0] x_i,
	output reg signed [W-1:0] y_o
);
	reg signed [W-1:0] lag;
	wire signed [2*W+1:0] d_x;
	wire signed [2*W+1:0] step;
	wire signed [2*W+1:0] lead;
	wire signed [W+1:0] sum;
	assign d_x = x_i - lag;
	// Lag state tracks input at the programmed bandwidth
	assign step = (d_x * bw_i) >>> F;
	// Output = lag + gain*(x - lag)
	assign lead = (d_x * gain_i) >>> F;
	// Part-select is unsigned, so re-sign it to keep negative lead values correct
	assign sum = lag + $signed(lead[W+1:0]);
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			lag <= {W{1'b0}};
			y_o <= {W{1'b0}};
		end else if (ce_i && upd_i) begin
			lag <= lag + step[W-1:0];
			if (gain_i == `STM_GAIN_ONE) begin
				// Unity gain bypasses the filter exactly
				y_o <= x_i; // [R04]
				lag <= x_i;
			end else if (sum > $signed({3'b000, {(W-1){1'b1}}}))
				y_o <= {1'b0, {(W-1){1'b1}}};
			else if (sum < -$signed({3'b000, {(W-1){1'b1}}}))
				y_o <= {1'b1, {(W-1){1'b0}}} + 1'b1;
			else
				y_o <= sum[W-1:0]; // [R01]
		end
	end
endmodule

// file: hw/stm_selector.v
// Speed regulator output stage and speed/torque mode selector.
// Assumes all inputs synchronous to clk_i; upd_i marks each control update.
//
// Overview of operation
// [R01] PI sum passes through lead/lag filter
// [R02] Enable flag bit 8 gates output
// [R03] Readable regulator output: limited and filtered
// [R04] Filter gain of one means bypass
// [R05] Adaption select bit 0 enables inertia adaption
// [R06] Software keeps adaption bandwidth equal regulator bandwidth
// [R07] Software sets error bandwidth five times regulator
// [R08] Mode 0 commands zero torque current
// [R09] Mode 1 uses regulator output
// [R10] Mode 2 uses external torque reference
// [R11] Mode 3 minimum, mode 4 maximum
// [R12] Min/max switch automatically each control cycle
// [R13] Mode 5 adds external torque to regulator
// [R14] Mode 6 takes smaller magnitude
// [R15] Modes 7 and 8 speed-limited min/max
// [R16] Zero torque mode keeps motor fluxed
// [R17] Inertia and friction torque added to regulator
// [R18] Torque reference: ref1 div, ref2 mult, trim
// [R19] Limited minimum forces speed on negative error
// [R20] Mode change takes effect at update boundary
`include "stm_consts.vh"
module stm_selector #(
	parameter W = `STM_DATA_W,
	parameter F = `STM_FRAC_W
) (
	// Clock, reset, enable
	input wire clk_i,
	input wire nrst_i,
	input wire ce_i,
	input wire upd_i,
	// Regulator inputs
	input wire signed [W-1:0] p_torque_i,
	input wire signed [W-1:0] i_torque_i,
	input wire signed [W-1:0] pos_limit_i,
	input wire signed [W-1:0] neg_limit_i,
	input wire signed [W-1:0] speed_error_i,
	input wire reg_enable_i,
	// Compensation torques
	input wire signed [W-1:0] inertia_torque_i,
	input wire signed [W-1:0] friction_torque_i,
	// Output filter settings
	input wire signed [W-1:0] output_filter_gain_i,
	input wire signed [W-1:0] output_filter_bandwidth_i,
	// Inertia adaption
	input wire [`STM_CTRL_W-1:0] adaption_select_i,
	// External torque reference
	input wire signed [W-1:0] torque_ref1_i,
	input wire signed [W-1:0] torque_ref1_div_i,
	input wire signed [W-1:0] torque_ref2_i,
	input wire signed [W-1:0] torque_ref2_mult_i,
	input wire signed [W-1:0] torque_trim_i,
	// Mode
	input wire [`STM_MODE_W-1:0] operating_mode_select_i,
	// Outputs
	output reg [`STM_CTRL_W-1:0] control_state_o,
	output reg signed [W-1:0] regulator_torque_output_o,
	output reg signed [W-1:0] torque_command_o,
	output reg flux_enable_o,
	output reg speed_mode_active_o,
	output reg forced_speed_o,
	output reg adaption_enable_o
);
	localparam signed [W+3:0] MAXV = {4'h0, 1'b0, {(W-1){1'b1}}};

	function signed [W-1:0] sat;
		input signed [W+3:0] v;
		begin
			if (v > MAXV)
				sat = MAXV[W-1:0];
			else if (v < -MAXV)
				sat = -MAXV[W-1:0];
			else
				sat = v[W-1:0];
		end
	endfunction

	function signed [W-1:0] mag;
		input signed [W-1:0] v;
		begin
			mag = v[W-1] ? -v : v;
		end
	endfunction

	reg [`STM_MODE_W-1:0] mode;
	reg forced;
	reg signed [W-1:0] pi_lim;
	wire signed [W-1:0] filt_out;
	wire signed [W+3:0] pi_sum;
	wire signed [2*W-1:0] ref2_prod;
	wire signed [2*W-1:0] ref2_shift;
	wire signed [W-1:0] ref1_scaled;
	wire signed [W+3:0] ext_sum;
	wire signed [W-1:0] ext_trq;
	wire signed [W-1:0] reg_trq;
	wire signed [W+3:0] reg_comp;

	assign pi_sum = p_torque_i + i_torque_i;

	// Output limits applied before filtering
	always @(posedge clk_i) begin
		if (!nrst_i)
			pi_lim <= {W{1'b0}};
		else if (ce_i && upd_i) begin
			if (pi_sum > pos_limit_i)
				pi_lim <= pos_limit_i;
			else if (pi_sum < neg_limit_i)
				pi_lim <= neg_limit_i;
			else
				pi_lim <= pi_sum[W-1:0];
		end
	end

	stm_lead_lag #(
		.W(W),
		.F(F)
	) u_filter (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.upd_i(upd_i),
		.gain_i(output_filter_gain_i), // [R01]
		.bw_i(output_filter_bandwidth_i),
		.x_i(pi_lim),
		.y_o(filt_out)
	);

	// Divide by zero treated as unity divisor
	assign ref1_scaled = (torque_ref1_div_i == {W{1'b0}}) ? torque_ref1_i : torque_ref1_i / torque_ref1_div_i;
	assign ref2_prod = torque_ref2_i * torque_ref2_mult_i;
	assign ref2_shift = ref2_prod >>> F;
	assign ext_sum = ref1_scaled + $signed(ref2_shift[W+3:0]) + torque_trim_i; // [R18]
	assign ext_trq = sat(ext_sum);

	// Forwarded only while enabled
	assign reg_comp = (control_state_o[`STM_CTRL_REG_EN_BIT] ? regulator_torque_output_o : {W{1'b0}})
		+ inertia_torque_i + friction_torque_i; // [R02] [R17]
	assign reg_trq = sat(reg_comp);

	always @(posedge clk_i) begin
		if (!nrst_i) begin
			mode <= `STM_MODE_RESET;
			forced <= 1'b0;
			control_state_o <= {`STM_CTRL_W{1'b0}};
			regulator_torque_output_o <= {W{1'b0}};
			torque_command_o <= {W{1'b0}};
			flux_enable_o <= 1'b0;
			speed_mode_active_o <= 1'b0;
			forced_speed_o <= 1'b0;
			adaption_enable_o <= 1'b0;
		end else if (ce_i) begin
			control_state_o[`STM_CTRL_REG_EN_BIT] <= reg_enable_i; // [R02]
			adaption_enable_o <= adaption_select_i[`STM_ADAPT_EN_BIT]; // [R05]
			flux_enable_o <= 1'b1; // [R16]
			regulator_torque_output_o <= filt_out; // [R03]
			if (upd_i) begin
				// Mode latched once per update so a cycle never mixes modes
				mode <= operating_mode_select_i; // [R20]
				case (mode)
				`STM_MODE_ZERO: begin
					torque_command_o <= {W{1'b0}}; // [R08] [R16]
					speed_mode_active_o <= 1'b0;
				end
				`STM_MODE_SPEED: begin
					torque_command_o <= reg_trq; // [R09]
					speed_mode_active_o <= 1'b1;
				end
				`STM_MODE_TORQUE: begin
					torque_command_o <= ext_trq; // [R10]
					speed_mode_active_o <= 1'b0;
				end
				`STM_MODE_MIN: begin
					torque_command_o <= (reg_trq < ext_trq) ? reg_trq : ext_trq; // [R11] [R12]
					speed_mode_active_o <= (reg_trq < ext_trq);
				end
				`STM_MODE_MAX: begin
					torque_command_o <= (reg_trq > ext_trq) ? reg_trq : ext_trq; // [R11] [R12]
					speed_mode_active_o <= (reg_trq > ext_trq);
				end
				`STM_MODE_SUM: begin
					torque_command_o <= sat(reg_trq + ext_trq); // [R13]
					speed_mode_active_o <= 1'b1;
				end
				`STM_MODE_ABSMIN: begin
					torque_command_o <= (mag(reg_trq) < mag(ext_trq)) ? reg_trq : ext_trq; // [R14]
					speed_mode_active_o <= (mag(reg_trq) < mag(ext_trq));
				end
				`STM_MODE_LAT_MIN: begin
					// No hysteresis: forced speed follows error sign
					if (speed_error_i[W-1]) begin
						forced <= 1'b1; // [R19]
						torque_command_o <= reg_trq; // [R15]
						speed_mode_active_o <= 1'b1;
					end else begin
						forced <= 1'b0;
						torque_command_o <= (reg_trq < ext_trq) ? reg_trq : ext_trq; // [R15]
						speed_mode_active_o <= (reg_trq < ext_trq);
					end
				end
				`STM_MODE_LAT_MAX: begin
					if (!speed_error_i[W-1] && speed_error_i != {W{1'b0}}) begin
						forced <= 1'b1;
						torque_command_o <= reg_trq; // [R15]
						speed_mode_active_o <= 1'b1;
					end else begin
						forced <= 1'b0;
						torque_command_o <= (reg_trq > ext_trq) ? reg_trq : ext_trq; // [R15]
						speed_mode_active_o <= (reg_trq > ext_trq);
					end
				end
				default: begin
					// Undefined codes fall back to zero torque
					torque_command_o <= {W{1'b0}};
					speed_mode_active_o <= 1'b0;
				end
				endcase
			end
			forced_speed_o <= forced;
		end
	end
endmodule

// file: bench/stm_selector_monitor.sv
// Port checker for the torque mode selector.
// Assumes it is bound into the top module and sees its ports only.
`include "stm_consts.vh"
module stm_selector_monitor #(parameter W = 16) (
	// Inputs of the block
	input wire clk_i,
	input wire nrst_i,
	input wire ce_i,
	input wire upd_i,
	input wire reg_enable_i,
	input wire signed [W-1:0] speed_error_i,
	input wire [15:0] adaption_select_i,
	input wire [3:0] operating_mode_select_i,
	// Outputs of the block
	input wire [15:0] control_state_o,
	input wire signed [W-1:0] torque_command_o,
	input wire flux_enable_o,
	input wire speed_mode_active_o,
	input wire forced_speed_o,
	input wire adaption_enable_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire up = ce_i && upd_i;
	wire [3:0] m = operating_mode_select_i;
	a_enable_bit_mirror: assert property ($past(ce_i) && $past(nrst_i) |-> control_state_o[8] == $past(reg_enable_i))
		else $error("enable bit does not follow regulator enable");
	a_spare_bits_zero: assert property ({control_state_o[15:9], control_state_o[7:0]} == 15'h0000)
		else $error("unused state bits set");
	a_adapt_follows: assert property ($past(ce_i) && $past(nrst_i) |-> adaption_enable_o == $past(adaption_select_i[0]))
		else $error("adaption enable does not follow select bit");
	a_cmd_holds: assert property ($past(nrst_i) && !$past(up) |-> $stable(torque_command_o) && $stable(speed_mode_active_o))
		else $error("command changed between updates");
	a_zero_cmd: assert property ((up && m == `STM_MODE_ZERO) [*2] |=> torque_command_o == 0)
		else $error("zero mode gives nonzero torque");
	a_speed_flag: assert property ((up && m == `STM_MODE_SPEED) [*2] |=> speed_mode_active_o)
		else $error("speed mode not flagged");
	a_torque_flag: assert property ((up && m == `STM_MODE_TORQUE) [*2] |=> !speed_mode_active_o)
		else $error("torque mode flagged as speed");
	a_flux_kept: assert property ($past(nrst_i) && $past(ce_i) |-> flux_enable_o)
		else $error("flux dropped after reset");
	a_forced_max: assert property ((up && m == `STM_MODE_LAT_MAX && speed_error_i > 0) [*3] |=> forced_speed_o)
		else $error("forced speed missing in limited maximum");
endmodule
bind stm_selector stm_selector_monitor #(.W(W)) stm_selector_monitor_i (.*);

// file: bench/stm_loop_model.sv
// Behavioural model of the downstream torque loop.
// Assumes the command is taken on every rising clock edge.
module stm_loop_model (
	input wire clk_i,
	input wire flux_enable_i,
	input wire signed [15:0] torque_cmd_i,
	output logic signed [15:0] applied_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// No torque can be produced without flux
	always @(posedge clk_i) applied_o <= flux_enable_i ? torque_cmd_i : 16'h0000;
endmodule

// file: bench/stm_selector_tb.sv
// Self-checking bench for the torque mode selector.
// Assumes the loop model sits on the command output.
`include "stm_consts.vh"
module stm_selector_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, nrst = 0, upd = 0, en = 1;
	logic signed [15:0] p = 0, i = 0, pl = 16'h7fff, nl = 16'h8000, se = 0, inr = 0, fr = 0;
	logic signed [15:0] g = 16'h1000, bw = 0, r1 = 0, d1 = 1, r2 = 0, m2 = 0, tr = 0;
	logic [15:0] asel = 0;
	logic [3:0] mode = 1;
	wire [15:0] cs, rto, cmd, app;
	wire fl, sm, fs, ae;
	int miscompares = 0, n_tests = 0;
	stm_selector stm_selector_i (.clk_i(clk), .nrst_i(nrst), .ce_i(1'b1), .upd_i(upd), .p_torque_i(p),
		.i_torque_i(i), .pos_limit_i(pl), .neg_limit_i(nl), .speed_error_i(se), .reg_enable_i(en),
		.inertia_torque_i(inr), .friction_torque_i(fr), .output_filter_gain_i(g), .output_filter_bandwidth_i(bw),
		.adaption_select_i(asel), .torque_ref1_i(r1), .torque_ref1_div_i(d1), .torque_ref2_i(r2),
		.torque_ref2_mult_i(m2), .torque_trim_i(tr), .operating_mode_select_i(mode), .control_state_o(cs),
		.regulator_torque_output_o(rto), .torque_command_o(cmd), .flux_enable_o(fl), .speed_mode_active_o(sm),
		.forced_speed_o(fs), .adaption_enable_o(ae));
	stm_loop_model stm_loop_model_i (.clk_i(clk), .flux_enable_i(fl), .torque_cmd_i(cmd), .applied_o(app));
	always #10 clk = ~clk;
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	// Update held long enough to flush the pipeline
	task automatic run;
		@(negedge clk) upd = 1;
		repeat (6) @(negedge clk);
		upd = 0;
		repeat (3) @(negedge clk);
	endtask
	task automatic t_modes;
		logic [15:0] e[10] = '{0, 16'h0300, 16'hfe00, 16'hfe00, 16'h0300, 16'h0100, 16'hfe00, 16'hfe00, 16'h0300, 0};
		p = 16'h0200;
		i = 16'h0100;
		r1 = 16'hfe00;
		se = 16'h0010;
		for (int k = 0; k < 10; k++) begin
			mode = 4'(k);
			run();
			chk("torque_command_o", e[k], cmd);
			if (k == 8) chk("forced_speed_o", 16'h0001, {15'h0, fs});
		end
		chk("flux_enable_o", 16'h0001, {15'h0, fl});
		chk("loop torque", 16'h0000, app);
		$display("modes done");
	endtask
	task automatic t_auto;
		mode = `STM_MODE_MIN;
		r1 = 16'h0400;
		run();
		chk("min speed side", 16'h0301, {cmd[15:1], sm});
		r1 = 16'h0100;
		run();
		chk("min torque side", 16'h0100, {cmd[15:1], sm});
		// Negative error forces speed although plain minimum would pick the reference
		mode = `STM_MODE_LAT_MIN;
		se = 16'hfff0;
		run();
		chk("limited min forced", 16'h0301, {cmd[15:1], sm});
		chk("forced_speed_o", 16'h0001, {15'h0, fs});
		se = 16'h0010;
		$display("auto switch done");
	endtask
	task automatic t_limit;
		mode = `STM_MODE_SPEED;
		pl = 16'h0400;
		nl = 16'hfc00;
		p = 16'h0300;
		i = 16'h0300;
		run();
		chk("regulator_torque_output_o", 16'h0400, rto);
		p = 16'hfd00;
		i = 16'hfd00;
		run();
		chk("regulator_torque_output_o", 16'hfc00, rto);
		g = 16'h0800;
		p = 16'h0400;
		i = 0;
		run();
		// Zero bandwidth holds lag at the last bypassed value fc00: fc00 + 0.5*(0400 - fc00)
		chk("filtered output", 16'h0000, rto);
		g = 16'h1000;
		$display("limit and filter done");
	endtask
	task automatic t_enable;
		en = 0;
		run();
		chk("control_state_o", 16'h0000, cs);
		chk("gated command", 16'h0000, cmd);
		en = 1;
		inr = 16'h0010;
		fr = 16'h0020;
		run();
		chk("control_state_o", 16'h0100, cs);
		chk("compensated command", 16'h0430, cmd);
		inr = 0;
		fr = 0;
		$display("enable done");
	endtask
	task automatic t_ref;
		mode = `STM_MODE_TORQUE;
		r1 = 16'h0400;
		d1 = 2;
		r2 = 16'h0400;
		m2 = 16'h0800;
		tr = 16'h0100;
		run();
		chk("torque reference", 16'h0500, cmd);
		// Adaption and error filter bandwidths live outside; software sets them to one and five times the regulator bandwidth
		asel = 16'h0001;
		repeat (2) @(negedge clk);
		chk("adaption_enable_o", 16'h0001, {15'h0, ae});
		asel = 16'hfffe;
		repeat (2) @(negedge clk);
		chk("adaption_enable_o", 16'h0000, {15'h0, ae});
		$display("reference and adaption done");
	endtask
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		nrst = 1;
		t_modes();
		t_auto();
		t_limit();
		t_enable();
		t_ref();
		final_report();
	end
	initial begin
		#100us;
		miscompares++;
		final_report();
	end
endmodule
